// ==== src/ppcs_cfg.svh ====
/*
  Offsets, field positions and reset values for the port physical-layer
  control and status block.
  Assumes a 32-bit classic Wishbone bus where register index n sits at byte address 4*n.
*/
`ifndef PPCS_CFG_SVH
`define PPCS_CFG_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define PPCS_IDX_P1_CTL 6'h02
`define PPCS_IDX_P1_STS 6'h04
`define PPCS_IDX_P2_BASE 6'h10
`define PPCS_P2_REGS 6
`define PPCS_P2_STEP 6'h02
`define PPCS_IDX_P1_ALIAS 6'h20

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define PPCS_CTL_LED_OFF 15
`define PPCS_CTL_TX_DIS 14
`define PPCS_CTL_RESTART 13
`define PPCS_CTL_FEF_DIS 12
`define PPCS_CTL_PWR_DN 11
`define PPCS_CTL_MDIX_DIS 10
`define PPCS_CTL_FORCE_MDIX 9
`define PPCS_CTL_LOOPBACK 8
`define PPCS_CTL_AN_EN 7
`define PPCS_CTL_SPEED 6
`define PPCS_CTL_DUPLEX 5
`define PPCS_CTL_ADV_HI 4
`define PPCS_CTL_RST 16'h009f

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define PPCS_STS_XALG 15
`define PPCS_STS_FEF 8
`define PPCS_STS_POL 13
`define PPCS_STS_RXFC 12
`define PPCS_STS_TXFC 11
`define PPCS_STS_SPEED 10
`define PPCS_STS_DUPLEX 9
`define PPCS_STS_MDI 7
`define PPCS_STS_LINK 5
`define PPCS_XALG_RST 1'h1

// ----------------------------------------------------------------------------
// alias register fields
// ----------------------------------------------------------------------------
`define PPCS_AL_LED_OFF 0
`define PPCS_AL_TX_DIS 1
`define PPCS_AL_FEF_DIS 2
`define PPCS_AL_MDIX_DIS 3
`define PPCS_AL_FORCE_MDIX 4
`define PPCS_AL_XALG 5
`define PPCS_AL_DUPLEX 8
`define PPCS_AL_RESTART 9
`define PPCS_AL_PWR_DN 11
`define PPCS_AL_AN_EN 12
`define PPCS_AL_SPEED 13
`define PPCS_AL_LOOPBACK 14

`define PPCS_P2_RST 16'h0000
`define PPCS_LED_ALL_OFF 4'hf

`endif

// ==== src/ppcs_pkg.sv ====
/*
  Types shared by the port physical-layer control and status block.
  Assumes ppcs_cfg.svh is on the include path.
*/
package ppcs_pkg;

  // status reported by the physical-layer core
  typedef struct packed {
    logic link_good;
    logic an_done;
    logic an_failed;
    logic an_speed_100;
    logic an_full;
    logic polarity_rev;
    logic rx_fc_active;
    logic tx_fc_active;
    logic mdi_straight;
    logic far_fault;
    logic [4:0] partner;
  } ppcs_phy_sts_t;

  // controls driven into the physical-layer core
  typedef struct packed {
    logic tx_disable;
    logic restart_an;
    logic fef_disable;
    logic power_down;
    logic auto_mdix_en;
    logic force_mdix;
    logic far_loopback;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
    logic xover_alg_select;
    logic [4:0] advertise;
  } ppcs_phy_ctl_t;

  // whole state of the top module
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] ctl;
    logic xalg;
    logic [15:0] sts;
    logic [5:0][15:0] p2;
    logic [3:0] indicator;
    ppcs_phy_ctl_t phy;
  } ppcs_state_t;

endpackage

// ==== src/ppcs_top.sv ====
/*
  Port 1 physical-layer control/status registers and the port 2 register bank,
  behind a classic Wishbone slave.
  Assumes a synchronous active-high reset, one 125 MHz clock, and status inputs
  from the physical-layer core that are synchronous to that clock.
*/
// Summary of operation
// - led off bit forces all indicators high
// - transmitter disable bit stops transmitter
// - writing restart bit restarts auto-negotiation
// - fault-disable bit stops fault detect and pattern
// - power-down bit powers the port down
// - bit disables automatic crossover detection
// - force crossed mode only when auto off
// - far-end loopback of port 2 through port 1
// - auto-negotiation enable, resets to one
// - forced speed when negotiation disabled
// - forced duplex when negotiation off or failed
// - advertised abilities, reset to one
// - writable crossover algorithm select, reset one
// - status shows receive polarity reversal
// - status shows receive and transmit flow control
// - status shows resolved speed and duplex
// - status shows far-end fault detected
// - status shows partner abilities
// - port 2 bank: six plain read/write words, reset to zero
`timescale 1ns/1ps
`include "ppcs_cfg.svh"

module ppcs_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] led_raw_i,
  input wire ppcs_pkg::ppcs_phy_sts_t phy_sts_i,
  output ppcs_pkg::ppcs_phy_ctl_t phy_ctl_o,
  output logic [3:0] port1_indicator_o
);
  import ppcs_pkg::*;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // alias view of the control bits in the other bank's layout
  function automatic logic [15:0] alias_pack(input logic [15:0] c, input logic xa);
    logic [15:0] a;
    a = 16'h0000;
    a[`PPCS_AL_LED_OFF] = c[`PPCS_CTL_LED_OFF];
    a[`PPCS_AL_TX_DIS] = c[`PPCS_CTL_TX_DIS];
    a[`PPCS_AL_FEF_DIS] = c[`PPCS_CTL_FEF_DIS];
    a[`PPCS_AL_MDIX_DIS] = c[`PPCS_CTL_MDIX_DIS];
    a[`PPCS_AL_FORCE_MDIX] = c[`PPCS_CTL_FORCE_MDIX];
    a[`PPCS_AL_XALG] = xa;
    a[`PPCS_AL_DUPLEX] = c[`PPCS_CTL_DUPLEX];
    a[`PPCS_AL_RESTART] = c[`PPCS_CTL_RESTART];
    a[`PPCS_AL_PWR_DN] = c[`PPCS_CTL_PWR_DN];
    a[`PPCS_AL_AN_EN] = c[`PPCS_CTL_AN_EN];
    a[`PPCS_AL_SPEED] = c[`PPCS_CTL_SPEED];
    a[`PPCS_AL_LOOPBACK] = c[`PPCS_CTL_LOOPBACK];
    return a;
  endfunction

  // --------------------------------------------------------------------------
  // state and decode
  // --------------------------------------------------------------------------
  ppcs_state_t st;
  ppcs_state_t next_st;
  logic [5:0] idx;
  logic req;
  logic wr;
  logic [15:0] alias_wr;
  logic [15:0] rd16;
  logic res_speed;
  logic res_duplex;

  // the register index is the word address; bits 1:0 are ignored
  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i & wb_stb_i;
  // writes land at the edge where the master samples ack
  assign wr = req & wb_we_i & st.ack;
  assign alias_wr = lane_merge(alias_pack(st.ctl, st.xalg), wb_dat_i, wb_sel_i);

  // --------------------------------------------------------------------------
  // speed and duplex resolution
  // --------------------------------------------------------------------------
  always_comb begin
    if (!st.ctl[`PPCS_CTL_AN_EN]) begin
      res_speed = st.ctl[`PPCS_CTL_SPEED];
      res_duplex = st.ctl[`PPCS_CTL_DUPLEX];
    end else if (phy_sts_i.an_failed) begin
      // speed still comes from parallel detection when negotiation fails
      res_speed = phy_sts_i.an_speed_100;
      res_duplex = st.ctl[`PPCS_CTL_DUPLEX];
    end else begin
      res_speed = phy_sts_i.an_speed_100;
      res_duplex = phy_sts_i.an_full;
    end
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  always_comb begin
    rd16 = 16'h0000; // unmapped words read as zero
    if (idx == `PPCS_IDX_P1_CTL) begin
      rd16 = st.ctl;
    end else if (idx == `PPCS_IDX_P1_STS) begin
      rd16 = st.sts;
    end else if (idx == `PPCS_IDX_P1_ALIAS) begin
      rd16 = alias_pack(st.ctl, st.xalg);
    end
    for (int k = 0; k < `PPCS_P2_REGS; k++) begin
      if (idx == 6'(`PPCS_IDX_P2_BASE + k * `PPCS_P2_STEP)) begin
        rd16 = st.p2[k];
      end
    end
  end

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // one-cycle ack, dropped in the cycle after it was given
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      next_st.rdata = {16'h0000, rd16};
    end

    // register writes
    if (wr) begin
      if (idx == `PPCS_IDX_P1_CTL) begin
        next_st.ctl = lane_merge(st.ctl, wb_dat_i, wb_sel_i);
      end else if (idx == `PPCS_IDX_P1_STS) begin
        if (wb_sel_i[1]) begin
          next_st.xalg = wb_dat_i[`PPCS_STS_XALG];
        end
      end else if (idx == `PPCS_IDX_P1_ALIAS) begin
        // the alias and the control word share storage, so both views agree
        next_st.ctl[`PPCS_CTL_LED_OFF] = alias_wr[`PPCS_AL_LED_OFF];
        next_st.ctl[`PPCS_CTL_TX_DIS] = alias_wr[`PPCS_AL_TX_DIS];
        next_st.ctl[`PPCS_CTL_FEF_DIS] = alias_wr[`PPCS_AL_FEF_DIS];
        next_st.ctl[`PPCS_CTL_MDIX_DIS] = alias_wr[`PPCS_AL_MDIX_DIS];
        next_st.ctl[`PPCS_CTL_FORCE_MDIX] = alias_wr[`PPCS_AL_FORCE_MDIX];
        next_st.xalg = alias_wr[`PPCS_AL_XALG];
        next_st.ctl[`PPCS_CTL_DUPLEX] = alias_wr[`PPCS_AL_DUPLEX];
        next_st.ctl[`PPCS_CTL_RESTART] = alias_wr[`PPCS_AL_RESTART];
        next_st.ctl[`PPCS_CTL_PWR_DN] = alias_wr[`PPCS_AL_PWR_DN];
        next_st.ctl[`PPCS_CTL_AN_EN] = alias_wr[`PPCS_AL_AN_EN];
        next_st.ctl[`PPCS_CTL_SPEED] = alias_wr[`PPCS_AL_SPEED];
        next_st.ctl[`PPCS_CTL_LOOPBACK] = alias_wr[`PPCS_AL_LOOPBACK];
      end
      for (int k = 0; k < `PPCS_P2_REGS; k++) begin
        if (idx == 6'(`PPCS_IDX_P2_BASE + k * `PPCS_P2_STEP)) begin
          next_st.p2[k] = lane_merge(st.p2[k], wb_dat_i, wb_sel_i);
        end
      end
    end

    // restart is a command: one pulse out, then the bit clears itself
    next_st.phy.restart_an = next_st.ctl[`PPCS_CTL_RESTART];
    next_st.ctl[`PPCS_CTL_RESTART] = 1'b0;

    // core controls follow the stored bits one cycle later
    next_st.phy.tx_disable = st.ctl[`PPCS_CTL_TX_DIS];
    next_st.phy.fef_disable = st.ctl[`PPCS_CTL_FEF_DIS];
    next_st.phy.power_down = st.ctl[`PPCS_CTL_PWR_DN];
    next_st.phy.auto_mdix_en = ~st.ctl[`PPCS_CTL_MDIX_DIS];
    next_st.phy.force_mdix = st.ctl[`PPCS_CTL_MDIX_DIS] & st.ctl[`PPCS_CTL_FORCE_MDIX];
    next_st.phy.far_loopback = st.ctl[`PPCS_CTL_LOOPBACK];
    next_st.phy.an_enable = st.ctl[`PPCS_CTL_AN_EN];
    next_st.phy.speed_100 = res_speed;
    next_st.phy.full_duplex = res_duplex;
    next_st.phy.xover_alg_select = st.xalg;
    next_st.phy.advertise = st.ctl[`PPCS_CTL_ADV_HI:0];

    // indicators: high means off on these pins
    next_st.indicator = st.ctl[`PPCS_CTL_LED_OFF] ? `PPCS_LED_ALL_OFF : led_raw_i;

    // status snapshot; a disabled fault detector reports no fault
    next_st.sts = {st.xalg, 1'b0,
                   phy_sts_i.polarity_rev,
                   phy_sts_i.rx_fc_active, phy_sts_i.tx_fc_active,
                   res_speed, res_duplex,
                   phy_sts_i.far_fault & ~st.ctl[`PPCS_CTL_FEF_DIS],
                   phy_sts_i.mdi_straight, 1'b0, phy_sts_i.link_good,
                   phy_sts_i.partner};
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctl <= `PPCS_CTL_RST;
      st.xalg <= `PPCS_XALG_RST;
      st.sts[`PPCS_STS_XALG] <= `PPCS_XALG_RST;
      st.indicator <= led_raw_i & 4'h0;
      st.phy.auto_mdix_en <= 1'b1;
      st.phy.an_enable <= 1'b1;
      st.phy.xover_alg_select <= `PPCS_XALG_RST;
      st.phy.advertise <= 5'(`PPCS_CTL_RST); // advertise field is the low five bits
      for (int k = 0; k < `PPCS_P2_REGS; k++) begin
        st.p2[k] <= `PPCS_P2_RST;
      end
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign phy_ctl_o = st.phy;
  assign port1_indicator_o = st.indicator;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  bus_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !st.ack) |=> st.ack ##1 !st.ack)
    else $error("ack not a single cycle pulse");

  led_off_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctl[`PPCS_CTL_LED_OFF] |=> (port1_indicator_o == `PPCS_LED_ALL_OFF))
    else $error("indicators not off");

  led_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctl[`PPCS_CTL_LED_OFF] |=> (port1_indicator_o == $past(led_raw_i)))
    else $error("indicators not following core");

  tx_disable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (phy_ctl_o.tx_disable == $past(st.ctl[`PPCS_CTL_TX_DIS])))
    else $error("transmitter disable mismatch");

  restart_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `PPCS_IDX_P1_CTL && wb_sel_i[1] && wb_dat_i[`PPCS_CTL_RESTART])
    |=> phy_ctl_o.restart_an ##1 (!phy_ctl_o.restart_an && !st.ctl[`PPCS_CTL_RESTART]))
    else $error("restart pulse wrong");

  fef_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctl[`PPCS_CTL_FEF_DIS] |=> (!st.sts[`PPCS_STS_FEF] && phy_ctl_o.fef_disable))
    else $error("fault reported while disabled");

  force_mdix_a: assert property (@(posedge clk_i) disable iff (rst_i)
    phy_ctl_o.force_mdix |-> !phy_ctl_o.auto_mdix_en)
    else $error("crossed mode forced with auto on");

  forced_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctl[`PPCS_CTL_AN_EN] |=> (phy_ctl_o.speed_100 == $past(st.ctl[`PPCS_CTL_SPEED])))
    else $error("forced speed not applied");

  forced_duplex_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st.ctl[`PPCS_CTL_AN_EN] || phy_sts_i.an_failed)
    |=> (phy_ctl_o.full_duplex == $past(st.ctl[`PPCS_CTL_DUPLEX])))
    else $error("forced duplex not applied");

  reset_value_a: assert property (@(posedge clk_i)
    rst_i |=> (st.ctl == `PPCS_CTL_RST && st.xalg == `PPCS_XALG_RST))
    else $error("control reset value wrong");

  status_partner_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (st.sts[4:0] == $past(phy_sts_i.partner)))
    else $error("partner abilities not reflected");

  p2_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `PPCS_IDX_P2_BASE && wb_sel_i[1:0] == 2'h3)
    |=> (st.p2[0] == $past(wb_dat_i[15:0])))
    else $error("port 2 register not written");

  alias_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `PPCS_IDX_P1_ALIAS && wb_sel_i[0])
    |=> (st.ctl[`PPCS_CTL_LED_OFF] == $past(wb_dat_i[`PPCS_AL_LED_OFF])))
    else $error("alias write not seen in control");

  // attempts starting on the releasing edge still see reset state, so they are skipped
  power_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (phy_ctl_o.power_down == $past(st.ctl[`PPCS_CTL_PWR_DN])))
    else $error("power-down control mismatch");

  auto_mdix_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (phy_ctl_o.auto_mdix_en == !$past(st.ctl[`PPCS_CTL_MDIX_DIS])))
    else $error("auto crossover enable mismatch");

  force_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (phy_ctl_o.force_mdix == $past(st.ctl[`PPCS_CTL_MDIX_DIS] & st.ctl[`PPCS_CTL_FORCE_MDIX])))
    else $error("forced crossed mode mismatch");

  loopback_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (phy_ctl_o.far_loopback == $past(st.ctl[`PPCS_CTL_LOOPBACK])))
    else $error("far-end loopback mismatch");

  an_enable_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (phy_ctl_o.an_enable == $past(st.ctl[`PPCS_CTL_AN_EN])))
    else $error("negotiation enable mismatch");

  advertise_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (phy_ctl_o.advertise == $past(st.ctl[`PPCS_CTL_ADV_HI:0])))
    else $error("advertised abilities mismatch");

  xalg_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (phy_ctl_o.xover_alg_select == $past(st.xalg)))
    else $error("crossover algorithm select mismatch");

  polarity_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (st.sts[`PPCS_STS_POL] == $past(phy_sts_i.polarity_rev)))
    else $error("polarity status mismatch");

  flow_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (st.sts[`PPCS_STS_RXFC] == $past(phy_sts_i.rx_fc_active)
      && st.sts[`PPCS_STS_TXFC] == $past(phy_sts_i.tx_fc_active)))
    else $error("flow control status mismatch");

  speed_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && !st.ctl[`PPCS_CTL_AN_EN]) |=> (st.sts[`PPCS_STS_SPEED] == $past(st.ctl[`PPCS_CTL_SPEED])
      && st.sts[`PPCS_STS_DUPLEX] == $past(st.ctl[`PPCS_CTL_DUPLEX])))
    else $error("forced speed or duplex status mismatch");

  negotiated_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && st.ctl[`PPCS_CTL_AN_EN] && !phy_sts_i.an_failed)
    |=> (st.sts[`PPCS_STS_SPEED] == $past(phy_sts_i.an_speed_100)
      && st.sts[`PPCS_STS_DUPLEX] == $past(phy_sts_i.an_full)))
    else $error("negotiated speed or duplex status mismatch");

  fault_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && !st.ctl[`PPCS_CTL_FEF_DIS]) |=> (st.sts[`PPCS_STS_FEF] == $past(phy_sts_i.far_fault)))
    else $error("far-end fault status mismatch");

  link_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (st.sts[`PPCS_STS_LINK] == $past(phy_sts_i.link_good)
      && st.sts[`PPCS_STS_MDI] == $past(phy_sts_i.mdi_straight)))
    else $error("link or pair mapping status mismatch");

  read_upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000))
    else $error("upper read half not zero");

  ack_needs_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(req))
    else $error("ack without a request");

  p2_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !st.ack && !wb_we_i && idx == `PPCS_IDX_P2_BASE) |=> (wb_dat_o[15:0] == $past(st.p2[0])))
    else $error("port 2 register read wrong");

  status_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `PPCS_IDX_P1_STS && wb_sel_i[1]) |=> (st.xalg == $past(wb_dat_i[`PPCS_STS_XALG])))
    else $error("crossover select not written");

  alias_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !st.ack && !wb_we_i && idx == `PPCS_IDX_P1_ALIAS)
    |=> (wb_dat_o[`PPCS_AL_AN_EN] == $past(st.ctl[`PPCS_CTL_AN_EN])))
    else $error("alias read disagrees with control");

endmodule // ppcs_top

// ==== tb/ppcs_phy_model.sv ====
/*
  Behavioural model of the physical-layer core and the link partner beyond it.
  Assumes the bench picks the partner's state on cmd_i and that every signal
  is synchronous to clk_i.
*/
`timescale 1ns/1ps

module ppcs_phy_model (
  input wire logic clk_i,
  input wire ppcs_pkg::ppcs_phy_ctl_t ctl_i,
  input wire ppcs_pkg::ppcs_phy_sts_t cmd_i,
  output ppcs_pkg::ppcs_phy_sts_t sts_o,
  output logic [3:0] led_o
);
  import ppcs_pkg::*;

  // ---------------------------------------------------------------------------
  // link state
  // ---------------------------------------------------------------------------
  // a powered-down port loses its link; with auto crossover off the pair
  // mapping follows the force bit instead of what the partner wants
  always_ff @(posedge clk_i) begin
    sts_o <= cmd_i;
    sts_o.link_good <= cmd_i.link_good & ~ctl_i.power_down;
    sts_o.mdi_straight <= ctl_i.auto_mdix_en ? cmd_i.mdi_straight : ~ctl_i.force_mdix;
  end

  // raw indicator levels in normal operation
  assign led_o = {sts_o.link_good, sts_o.an_speed_100, sts_o.an_full, sts_o.polarity_rev};
endmodule // ppcs_phy_model

// ==== tb/ppcs_top_bench.sv ====
/*
  Self-checking bench for the port control/status registers.
  Assumes the Wishbone slave answers one cycle after a request and the
  partner model stands on the physical-layer side.
*/
`timescale 1ns/1ps

module ppcs_top_bench;
  import ppcs_pkg::*;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] led_raw;
  logic [3:0] port1_indicator_o;
  ppcs_phy_sts_t phy_sts;
  ppcs_phy_sts_t cmd = '0;
  ppcs_phy_ctl_t phy_ctl_o;
  logic [31:0] rdq [$];
  logic [15:0] p2 [6];
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 72983;
  int restarts = 0;

  // ---------------------------------------------------------------------------
  // clock, design and partner
  // ---------------------------------------------------------------------------
  always #4 clk_i = ~clk_i;

  ppcs_top ppcs_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .led_raw_i(led_raw), .phy_sts_i(phy_sts), .phy_ctl_o(phy_ctl_o), .port1_indicator_o(port1_indicator_o));

  ppcs_phy_model ppcs_phy_model_i (.clk_i(clk_i), .ctl_i(phy_ctl_o), .cmd_i(cmd), .sts_o(phy_sts),
    .led_o(led_raw));

  // ---------------------------------------------------------------------------
  // comparison and verdict
  // ---------------------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    cmp({16'h0, got}, {16'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang in the handshake ends the run here; the whole run needs under 500 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // read results are compared at the acknowledging edge, oldest note first
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && !we && rdq.size() > 0) begin
      cmp(wb_dat_o, rdq.pop_front());
    end
  end

  // restart is a one-cycle pulse, so it is counted every cycle rather than polled
  always @(posedge clk_i) begin
    if (phy_ctl_o.restart_an === 1'b1) begin
      restarts++;
    end
  end

  // ---------------------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------------------
  // request is held until ack is seen, then one idle cycle follows
  task automatic bus(input logic [7:0] a, input logic [15:0] d, input logic w, input logic [3:0] s);
    adr <= a;
    dat <= {16'h0, d};
    we <= w;
    sel <= s;
    cyc <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(a, d, 1'b1, 4'h3);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rdq.push_back({16'h0, exp});
    bus(a, 16'h0, 1'b0, 4'h3);
  endtask

  // ---------------------------------------------------------------------------
  // expected values
  // ---------------------------------------------------------------------------
  function automatic ppcs_phy_ctl_t ctl_exp(input logic [15:0] c, input logic x, input ppcs_phy_sts_t s);
    logic [15:0] t;
    t = sts_exp(c, x, s); // resolved speed and duplex sit in bits 10 and 9
    return {c[14], 1'b0, c[12], c[11], ~c[10], c[10] & c[9], c[8], c[7], t[10], t[9], x, c[4:0]};
  endfunction

  function automatic logic [15:0] sts_exp(input logic [15:0] c, input logic x, input ppcs_phy_sts_t s);
    logic spd;
    logic dup;
    logic mdi;
    spd = c[7] ? s.an_speed_100 : c[6];
    dup = (c[7] && !s.an_failed) ? s.an_full : c[5];
    mdi = c[10] ? ~c[9] : s.mdi_straight;
    return {x, 1'b0, s.polarity_rev, s.rx_fc_active, s.tx_fc_active, spd, dup, s.far_fault & ~c[12],
      mdi, 1'b0, s.link_good & ~c[11], s.partner};
  endfunction

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    logic [15:0] c;
    logic x;
    logic [31:0] r;
    ppcs_phy_sts_t s;
    int n;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    c = 16'h009f;
    x = 1'b1;
    s = '0;
    rd(8'h08, 16'h009f);
    chk_out(phy_ctl_o, ctl_exp(c, x, s));
    rd(8'h10, sts_exp(c, x, s));
    rd(8'h80, 16'h1020);
    for (int k = 0; k < 6; k++) rd(8'(8'h40 + 8 * k), 16'h0000);
    // random control words against random partner states
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      c = r[15:0];
      c[13] = 1'b0;
      s = r[30:16];
      cmd <= s;
      wr(8'h08, c);
      repeat (5) @(posedge clk_i);
      rd(8'h08, c);
      chk_out(phy_ctl_o, ctl_exp(c, x, s));
      chk_out({12'h0, port1_indicator_o}, {12'h0, c[15] ? 4'hf : led_raw});
      rd(8'h10, sts_exp(c, x, s));
    end
    // restart bit gives one pulse and reads back clear
    n = restarts;
    wr(8'h08, c | 16'h2000);
    repeat (6) @(posedge clk_i);
    chk_out(16'(restarts - n), 16'h0001);
    rd(8'h08, c);
    // writable crossover select beside read-only status bits
    wr(8'h10, 16'h7fff);
    x = 1'b0;
    repeat (5) @(posedge clk_i);
    rd(8'h10, sts_exp(c, x, s));
    chk_out(phy_ctl_o, ctl_exp(c, x, s));
    // alias write: led off, crossover select, loopback; negotiation off
    wr(8'h80, 16'h4021);
    c = {8'h81, 3'b000, c[4:0]};
    x = 1'b1;
    repeat (5) @(posedge clk_i);
    rd(8'h08, c);
    rd(8'h80, 16'h4021);
    chk_out(phy_ctl_o, ctl_exp(c, x, s));
    rd(8'h10, sts_exp(c, x, s));
    // port 2 bank, one byte lane, unmapped place
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      p2[k] = r[15:0];
      wr(8'(8'h40 + 8 * k), p2[k]);
    end
    for (int k = 0; k < 6; k++) rd(8'(8'h40 + 8 * k), p2[k]);
    bus(8'h40, 16'hffff, 1'b1, 4'h1);
    rd(8'h40, {p2[0][15:8], 8'hff});
    wr(8'hfc, 16'h1234);
    rd(8'hfc, 16'h0000);
    tally_and_finish();
  end
endmodule // ppcs_top_bench
